// ---- inc/sar_pkg.sv ----
// constants, types and helpers shared by the converter control block
package sar_pkg;

  // ----------------------------------------------------------------
  // register map and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL1_ADDR = 8'h6C;
  localparam logic [7:0] CTL2_ADDR = 8'h6D;
  localparam logic [7:0] RESH_ADDR = 8'h6E;
  localparam logic [7:0] RESL_ADDR = 8'h6F;
  localparam int C1_CHAN  = 4;
  localparam int C1_DONE  = 3;
  localparam int C1_BUSY  = 2;
  localparam int C1_REF   = 1;
  localparam int C1_START = 0;
  localparam int C2_EIGHT = 7;
  localparam int C2_SAMP  = 5;
  localparam int C2_TRIG  = 4;
  localparam int C2_IE    = 3;
  localparam int C2_CONT  = 2;
  localparam int C2_DIV   = 0;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] RESL_RST = 8'h00;
  localparam logic [1:0] RESH_RST = 2'h0;
  localparam int NUM_CH = 6;
  localparam int RES_W  = 10;

  // ----------------------------------------------------------------
  // timing counts, in conversion clock steps and machine clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] SAMP_STEPS0 = 6'h04;
  localparam logic [5:0] SAMP_STEPS1 = 6'h08;
  localparam logic [5:0] SAMP_STEPS2 = 6'h10;
  localparam logic [5:0] SAMP_STEPS3 = 6'h20;
  localparam logic [2:0] DIV_LAST0   = 3'h0;
  localparam logic [2:0] DIV_LAST1   = 3'h1;
  localparam logic [2:0] DIV_LAST2   = 3'h3;
  localparam logic [2:0] DIV_LAST3   = 3'h7;
  localparam logic [9:0] TRIAL_MSB   = 10'h200;

  function automatic logic [5:0] sampSteps(input logic [1:0] sel);
    case (sel)
      2'h0:    sampSteps = SAMP_STEPS0;
      2'h1:    sampSteps = SAMP_STEPS1;
      2'h2:    sampSteps = SAMP_STEPS2;
      default: sampSteps = SAMP_STEPS3;
    endcase
  endfunction

  function automatic logic [2:0] divLast(input logic [1:0] sel);
    case (sel)
      2'h0:    divLast = DIV_LAST0;
      2'h1:    divLast = DIV_LAST1;
      2'h2:    divLast = DIV_LAST2;
      default: divLast = DIV_LAST3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SAMPLE = 2'b01, ST_RESOLVE = 2'b10} sar_state_t;

  typedef struct packed {
    sar_state_t state;
    logic [5:0] cnt;
    logic [3:0] bitIdx;
    logic [9:0] trial;
    logic [9:0] result;
    logic       donePulse;
  } sar_eng_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
    logic       trigPrev;
    logic       trigEdge;
  } sar_tick_t;

  typedef struct packed {
    logic [3:0] chan;
    logic       done;
    logic       refSw;
    logic [7:0] ctl2;
    logic [1:0] resHigh;
    logic [7:0] resLow;
    logic [7:0] rdata;
    logic       irq;
    logic [5:0] route;
  } sar_top_t;

endpackage

// ---- inc/sar_step_if.sv ----
// control to approximation engine handshake
`timescale 1ns/1ps
`default_nettype none
interface sar_step_if;
  logic       start;
  logic       tick;
  logic [1:0] sampSel;
  logic       cmpHigh;
  logic       busy;
  logic       sampling;
  logic       done;
  logic [9:0] result;
  logic [9:0] trial;
  modport ctrl   (output start, tick, sampSel, cmpHigh, input busy, sampling, done, result, trial);
  modport engine (input start, tick, sampSel, cmpHigh, output busy, sampling, done, result, trial);
endinterface
`default_nettype wire

// ---- design/sar_tick_gen.sv ----
// conversion clock divider and trigger edge detector
`timescale 1ns/1ps
`default_nettype none
module sar_tick_gen
  import sar_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // control
  input  wire logic [1:0] divSel,
  input  wire logic       restart,
  input  wire logic       trigSel,
  input  wire logic       trigClkA,
  input  wire logic       trigClkB,
  // events
  output logic            tick,
  output logic            trigEdge
);
  sar_tick_t s;
  sar_tick_t next_s;
  logic      trigIn;

  assign trigIn   = trigSel ? trigClkB : trigClkA;
  assign tick     = s.tick;
  assign trigEdge = s.trigEdge;

  always_comb
  begin
    next_s          = s;
    next_s.trigPrev = trigIn;
    next_s.trigEdge = trigIn && !s.trigPrev;
    // restarting keeps step boundaries aligned to the launch
    if (restart)
    begin
      next_s.cnt  = 3'h0;
      next_s.tick = 1'b0;
    end
    else if (s.cnt >= divLast(divSel))
    begin
      next_s.cnt  = 3'h0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.cnt  = s.cnt + 3'h1;
      next_s.tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_div_by_one: assert property (divSel == 2'h0 && !restart |=> tick) else $error("divide by one missed a tick");
  chk_div_by_eight: assert property (divSel == 2'h3 && tick && !restart [*1] ##1 (divSel == 2'h3 && !restart) [*7]
    |-> !$past(tick, 6)) else $error("divide by eight ticked early");
endmodule
`default_nettype wire

// ---- design/sar_approx.sv ----
// sampling phase and bit by bit approximation engine
`timescale 1ns/1ps
`default_nettype none
module sar_approx
  import sar_pkg::*;
(
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   resetn,
  // step handshake
  sar_step_if.engine  stp
);
  sar_eng_t s;
  sar_eng_t next_s;

  assign stp.busy     = s.state != ST_IDLE;
  assign stp.sampling = s.state == ST_SAMPLE;
  assign stp.done     = s.donePulse;
  assign stp.result   = s.result;
  assign stp.trial    = s.trial;

  always_comb
  begin
    next_s           = s;
    next_s.donePulse = 1'b0;
    // a start always wins, so a running conversion is dropped and relaunched
    if (stp.start)
    begin
      next_s.state = ST_SAMPLE;
      next_s.cnt   = sampSteps(stp.sampSel) - 6'h1;
      next_s.trial = '0;
    end
    else
    begin
      unique case (s.state)
        ST_IDLE: ;
        ST_SAMPLE:
          if (stp.tick)
          begin
            if (s.cnt == 6'h0)
            begin
              next_s.state  = ST_RESOLVE;
              next_s.bitIdx = 4'(RES_W - 1);
              next_s.trial  = TRIAL_MSB;
            end
            else
              next_s.cnt = s.cnt - 6'h1;
          end
        ST_RESOLVE:
          if (stp.tick)
          begin
            if (!stp.cmpHigh)
              next_s.trial[s.bitIdx] = 1'b0;
            if (s.bitIdx == 4'h0)
            begin
              next_s.state     = ST_IDLE;
              next_s.result    = next_s.trial;
              next_s.donePulse = 1'b1;
            end
            else
            begin
              next_s.bitIdx               = s.bitIdx - 4'h1;
              next_s.trial[s.bitIdx - 1]  = 1'b1;
            end
          end
        default: next_s.state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_msb_trial_first: assert property (s.state == ST_SAMPLE && stp.tick && s.cnt == 6'h0 && !stp.start
    |=> s.trial == TRIAL_MSB && s.bitIdx == 4'h9) else $error("approximation did not open at the top bit");
endmodule
`default_nettype wire

// ---- design/sar_converter_control.sv ----
// register file, trigger selection and flags of the approximation converter
//
// How it works
// - a pin is routed only if its direction bit is input and channel names it
// - upper nibble of first control register picks analog input zero to five
// - a start write carrying a new channel converts that new channel
// - completion flag sets on every finish, whatever the interrupt enable
// - interrupt output is high exactly while completion flag and enable are one
// - writing zero clears the completion flag, writing one changes nothing
// - read-modify-write read phase returns one for the completion flag
// - converting flag reads one through the whole conversion and ignores writes
// - bit one drives the reference supply cut-off switch
// - writing one to start launches a conversion; zero never aborts; reads zero
// - start writes are ignored while continuous triggering is enabled
// - start write during a software conversion abandons it and restarts
// - trigger comes from start bit or from the selected trigger clock
// - clock select gives one, two, four or eight machine clocks per step
// - continuous mode starts on each rising trigger edge until disabled
// - result stored at the end on the same edge as busy clears and done sets; old result held
// - eight-bit mode puts the top eight bits low and zeroes the high bits
`timescale 1ns/1ps
`default_nettype none
module sar_converter_control
  import sar_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic       regRmw,
  output logic      [7:0] regRdata,
  // port direction and analog routing
  input  wire logic [5:0] portDirIn,
  output logic      [5:0] analogRouteEn,
  // analog front end
  input  wire logic       cmpHigh,
  output logic      [9:0] dacTrial,
  output logic            sampleHold,
  output logic            refSwitchOn,
  // trigger clocks
  input  wire logic       trigClkA,
  input  wire logic       trigClkB,
  // interrupt controller
  output logic            irqReq
);

  // ----------------------------------------------------------------
  // state and sub-blocks
  // ----------------------------------------------------------------
  sar_top_t   s;
  sar_top_t   next_s;
  sar_step_if stp ();
  logic       trigEdge;
  logic       contMode;
  logic       wrCtl1;
  logic       wrCtl2;
  logic       swStart;
  logic       trgStart;
  logic       convFlag;

  sar_tick_gen u_tick (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .divSel   (s.ctl2[C2_DIV +: 2]),
    .restart  (stp.start),
    .trigSel  (s.ctl2[C2_TRIG]),
    .trigClkA (trigClkA),
    .trigClkB (trigClkB),
    .tick     (stp.tick),
    .trigEdge (trigEdge)
  );

  sar_approx u_eng (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .stp     (stp)
  );

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  assign contMode    = s.ctl2[C2_CONT];
  assign wrCtl1      = regWr && regAddr == CTL1_ADDR;
  assign wrCtl2      = regWr && regAddr == CTL2_ADDR;
  // a start write restarts, even mid-conversion, unless continuous triggering is enabled
  assign swStart     = wrCtl1 && regWdata[C1_START] && !contMode;
  assign trgStart    = contMode && trigEdge;
  assign stp.start   = swStart || trgStart;
  assign stp.sampSel = s.ctl2[C2_SAMP +: 2];
  assign stp.cmpHigh = cmpHigh;
  // the finishing cycle still reads busy so result, busy and done move together
  assign convFlag    = stp.busy || stp.done;

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops except sampleHold, decoded from the engine state
  // ----------------------------------------------------------------
  assign regRdata      = s.rdata;
  assign irqReq        = s.irq;
  assign analogRouteEn = s.route;
  assign refSwitchOn   = s.refSw;
  assign dacTrial      = stp.trial;
  assign sampleHold    = stp.sampling;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;

    // first control register: channel, reference switch, flag clear
    if (wrCtl1)
    begin
      next_s.chan  = regWdata[C1_CHAN +: 4];
      next_s.refSw = regWdata[C1_REF];
    end

    // a finish in the same cycle as a clearing write keeps the flag set
    next_s.done = stp.done || (s.done && !(wrCtl1 && !regWdata[C1_DONE]));

    if (wrCtl2)
      next_s.ctl2 = regWdata;

    // old result stays visible until the new one is complete
    if (stp.done)
    begin
      if (s.ctl2[C2_EIGHT])
      begin
        next_s.resHigh = 2'h0;
        next_s.resLow  = stp.result[9:2];
      end
      else
      begin
        next_s.resHigh = stp.result[9:8];
        next_s.resLow  = stp.result[7:0];
      end
    end

    // read data stand for one cycle only
    next_s.rdata = 8'h00;
    if (regRd)
    begin
      unique case (regAddr)
        CTL1_ADDR: next_s.rdata = {s.chan, s.done || regRmw, convFlag, s.refSw, 1'b0};
        CTL2_ADDR: next_s.rdata = s.ctl2;
        RESH_ADDR: next_s.rdata = {6'h00, s.resHigh};
        RESL_ADDR: next_s.rdata = s.resLow;
        default:   next_s.rdata = 8'h00;
      endcase
    end

    // irq built from next state so it tracks the flags without lag
    next_s.irq = next_s.done && next_s.ctl2[C2_IE];

    // unselected pins and pins driven as outputs stay general purpose
    for (int i = 0; i < NUM_CH; i++)
      next_s.route[i] = !portDirIn[i] && next_s.chan == 4'(i);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      s         <= '0;
      s.chan    <= CHAN_RST;
      s.ctl2    <= CTL2_RST;
      s.resHigh <= RESH_RST;
      s.resLow  <= RESL_RST;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence swLaunch;
    swStart && !trgStart;
  endsequence

  sequence finishSeq;
    stp.done;
  endsequence

  sequence clearWrite;
    wrCtl1 && !regWdata[C1_DONE] && !stp.done;
  endsequence

  property pDoneAfterFinish;
    finishSeq |=> s.done && !convFlag;
  endproperty

  property pResultHeld;
    stp.busy && !stp.done ##1 stp.busy && !stp.done |-> $stable(s.resLow) && $stable(s.resHigh);
  endproperty

  chk_irq_tracks_flag: assert property (irqReq == (s.done && s.ctl2[C2_IE]))
    else $error("interrupt output disagrees with flag and enable");
  chk_done_on_finish: assert property (pDoneAfterFinish)
    else $error("completion flag not set after finish");
  chk_clear_by_zero: assert property (clearWrite |=> !s.done)
    else $error("writing zero left the completion flag set");
  chk_one_keeps_flag: assert property (wrCtl1 && regWdata[C1_DONE] && s.done |=> s.done)
    else $error("writing one disturbed the completion flag");
  chk_rmw_reads_one: assert property (regRd && regAddr == CTL1_ADDR && regRmw |=> regRdata[C1_DONE])
    else $error("read-modify-write read returned zero for the flag");
  chk_start_reads_zero: assert property (regRd && regAddr == CTL1_ADDR |=> !regRdata[C1_START] &&
    regRdata[C1_BUSY] == $past(convFlag)) else $error("start bit or busy read back wrong");
  chk_sw_launch: assert property (swLaunch |=> stp.sampling)
    else $error("start write did not launch sampling");
  chk_cont_ignores: assert property (contMode && wrCtl1 && regWdata[C1_START] && !trigEdge && !stp.busy
    |=> !stp.busy) else $error("start write acted in continuous mode");
  chk_trig_edge: assert property (contMode && trigEdge |=> stp.sampling)
    else $error("trigger edge did not launch a conversion");
  chk_result_held: assert property (pResultHeld)
    else $error("result changed during conversion");
  chk_high_zero_eight: assert property (stp.done && s.ctl2[C2_EIGHT] |=> s.resHigh == 2'h0 &&
    s.resLow == $past(stp.result[9:2])) else $error("eight-bit result misplaced");
  chk_route_selects: assert property (regWr && !stp.done |=> analogRouteEn ==
    ($past(portDirIn) == 6'h3F ? 6'h00 : analogRouteEn) || (analogRouteEn & $past(portDirIn)) == 6'h00)
    else $error("pin routed while driven as output");
  chk_channel_taken: assert property (swStart && !trgStart && regWdata[C1_CHAN +: 4] < 4'h6 && !portDirIn[regWdata[6:4]]
    |=> analogRouteEn[$past(regWdata[6:4])]) else $error("start write did not take the new channel");
endmodule
`default_nettype wire

// ---- tb/test_sar_converter_control.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_sar_converter_control
  import sar_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic       ref_clk;
  logic       resetn;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic       regRmw;
  logic [7:0] regRdata;
  logic [5:0] portDirIn;
  logic [5:0] analogRouteEn;
  logic       cmpHigh;
  logic [9:0] dacTrial;
  logic       sampleHold;
  logic       refSwitchOn;
  logic       trigClkA;
  logic       trigClkB;
  logic       irqReq;
  logic [9:0] vin;
  int         seed;
  int         error_cnt;
  int         comparisons;
  int         cyc;

  sar_converter_control sar_converter_control_inst (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRmw(regRmw), .regRdata(regRdata), .portDirIn(portDirIn),
    .analogRouteEn(analogRouteEn), .cmpHigh(cmpHigh), .dacTrial(dacTrial), .sampleHold(sampleHold),
    .refSwitchOn(refSwitchOn), .trigClkA(trigClkA), .trigClkB(trigClkB), .irqReq(irqReq)
  );

  // ideal comparator: the held input against the trial code
  assign cmpHigh = (vin >= dacTrial);

  always #10 ref_clk = ~ref_clk;

  always @(posedge ref_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    regRmw  <= m;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    regRmw  <= 1'b0;
    @(negedge ref_clk);
    d = regRdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic m, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, m, d);
    chk($sformatf("register %h", a), 10'(exp), 10'(d));
  endtask

  // polls the converting flag; reads cost two cycles, so the end time is coarse
  task automatic wait_idle(output int t);
    logic [7:0] d;
    int         n;
    n = 0;
    d = 8'hFF;
    while (d[C1_BUSY] !== 1'b0 && n < 600)
    begin
      rd(CTL1_ADDR, 1'b0, d);
      n++;
    end
    t = cyc;
    chk("idle wait", 10'h000, 10'(n >= 600));
  endtask

  task automatic trig(input logic [7:0] c2, input logic a, input logic b, input logic exp);
    logic [7:0] d;
    int         t;
    wr(CTL2_ADDR, c2);
    trigClkA <= a;
    trigClkB <= b;
    repeat (4) @(posedge ref_clk);
    rd(CTL1_ADDR, 1'b0, d);
    chk("trigger start", 10'(exp), 10'(d[C1_BUSY]));
    wait_idle(t);
    trigClkA <= 1'b0;
    trigClkB <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [3:0] ch;
    logic [1:0] samp;
    logic [1:0] div;
    logic       eight;
    logic [5:0] dir;
    logic [1:0] prevH;
    logic [7:0] prevL;
    logic [7:0] w;
    int         t0;
    int         t1;
    int         lo;
    int         hi;
    ref_clk = 1'b0;
    resetn = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    regRmw = 1'b0;
    portDirIn = 6'h00;
    trigClkA = 1'b0;
    trigClkB = 1'b0;
    vin = 10'h000;
    seed = 42374;
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    prevH = 2'h0;
    prevL = 8'h00;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    rdchk(CTL1_ADDR, 1'b0, 8'h00);
    rdchk(CTL2_ADDR, 1'b0, 8'h00);
    rdchk(RESH_ADDR, 1'b0, 8'h00);
    rdchk(RESL_ADDR, 1'b0, 8'h00);
    rdchk(8'h70, 1'b0, 8'h00);
    w = 8'($random(seed));
    wr(CTL2_ADDR, w);
    rdchk(CTL2_ADDR, 1'b0, w);
    wr(RESH_ADDR, 8'hFF);
    wr(RESL_ADDR, 8'hFF);
    rdchk(RESH_ADDR, 1'b0, 8'h00);
    rdchk(RESL_ADDR, 1'b0, 8'h00);
    wr(CTL2_ADDR, 8'h00);
    wr(CTL1_ADDR, 8'h04);
    rdchk(CTL1_ADDR, 1'b0, 8'h00);
    // every sample window against every divider, corner codes at both ends
    for (int i = 0; i < 16; i++)
    begin
      samp = 2'(i >> 2);
      div = 2'(i);
      ch = 4'(($random(seed) & 32'h7FFF) % NUM_CH);
      vin = (i == 0) ? 10'h000 : (i == 15) ? 10'h3FF : 10'($random(seed));
      eight = 1'($random(seed));
      dir = 6'($random(seed));
      portDirIn <= dir;
      lo = ((4 << samp) + 9) * (1 << div);
      hi = ((4 << samp) + 11) * (1 << div) + 8;
      wr(CTL2_ADDR, {eight, samp, 1'b0, 1'b0, 1'b0, div});
      wr(CTL1_ADDR, {ch, 4'hB});
      t0 = cyc;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("sampling", 10'h001, 10'(sampleHold));
      chk("route", 10'(dir[ch[2:0]] ? 6'h00 : 6'h01 << ch), 10'(analogRouteEn));
      chk("reference switch", 10'h001, 10'(refSwitchOn));
      rdchk(RESH_ADDR, 1'b0, {6'h00, prevH});
      rdchk(RESL_ADDR, 1'b0, prevL);
      wr(CTL1_ADDR, {ch, 4'hA});
      if (i == 5)
      begin
        wr(CTL1_ADDR, {ch, 4'hB});
        t0 = cyc;
      end
      wait_idle(t1);
      chk("conversion time", 10'h001, 10'(t1 - t0 >= lo && t1 - t0 <= hi));
      prevH = eight ? 2'h0 : vin[9:8];
      prevL = eight ? vin[9:2] : vin[7:0];
      rdchk(RESH_ADDR, 1'b0, {6'h00, prevH});
      rdchk(RESL_ADDR, 1'b0, prevL);
      rdchk(CTL1_ADDR, 1'b0, {ch, 4'hA});
      chk("irq disabled", 10'h000, 10'(irqReq));
    end
    wr(CTL2_ADDR, 8'h08);
    repeat (2) @(negedge ref_clk);
    chk("irq enabled", 10'h001, 10'(irqReq));
    wr(CTL1_ADDR, 8'h0A);
    rdchk(CTL1_ADDR, 1'b0, 8'h0A);
    wr(CTL1_ADDR, 8'h02);
    rdchk(CTL1_ADDR, 1'b0, 8'h02);
    chk("irq cleared", 10'h000, 10'(irqReq));
    rdchk(CTL1_ADDR, 1'b1, 8'h0A);
    // continuous triggering: start bit locked out, selected edge only
    wr(CTL2_ADDR, 8'h04);
    wr(CTL1_ADDR, 8'h03);
    repeat (3) @(posedge ref_clk);
    rdchk(CTL1_ADDR, 1'b0, 8'h02);
    trig(8'h04, 1'b0, 1'b1, 1'b0);
    trig(8'h04, 1'b1, 1'b0, 1'b1);
    trig(8'h14, 1'b1, 1'b0, 1'b0);
    trig(8'h14, 1'b0, 1'b1, 1'b1);
    trig(8'h00, 1'b1, 1'b1, 1'b0);
    give_verdict();
  end

  // the sequence needs about two thousand cycles; this bound is twenty times that
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
